// File: common/clkctl_cfg.svh
// Constants for the clock control and status pin block.
// Assumes a single 25 MHz system clock and a byte-addressed AXI4-Lite map.
`ifndef CLKCTL_CFG_SVH
`define CLKCTL_CFG_SVH

// ==========================================================================
// Register map (byte offsets)
`define REG_SELECT 8'h00
`define REG_STEP 8'h04
`define REG_OUT_EN 8'h08
`define REG_STATUS 8'h0c
`define REG_OFFSET_BASE 8'h10

// ==========================================================================
// Field positions and reset values
`define SELECT_WIDTH 4
`define STEP_WIDTH 16
`define SELECT_RESET 4'h0
`define STEP_RESET 16'h0001
`define STATUS_LOCKED_BIT 0
`define STATUS_LOST_LSB 1
`define STATUS_XTAL_BIT 5
`define STATUS_DISABLE_BIT 6
`define STATUS_RESET_BIT 7

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 40
`define LOS_TIME_NS 2000
`define LOS_CYCLES ((`LOS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: common/clkctl_pkg.sv
// Types shared by the clock control and status pin block.
// Assumes numbers come from clkctl_cfg.svh.
package clkctl_pkg;

   // ========================================================================
   // Status carried from the monitors to the pins and the status register
   typedef struct packed {
      logic reset_active;
      logic outputs_disabled;
      logic crystal_lost;
      logic [3:0] input_lost;
      logic locked;
   } status_type;

   // ========================================================================
   // Bus channel states
   typedef enum logic [0:0] {wr_collect, wr_answer} write_state_type;
   typedef enum logic [0:0] {rd_idle, rd_answer} read_state_type;

endpackage : clkctl_pkg

// File: logic/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the pins are quasi-static relative to aclk; only the second stage is output.
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic clock_enable, // Freezes the stages while low
   input wire logic [WIDTH-1:0] pin_in, // Asynchronous levels
   output logic [WIDTH-1:0] sync_out // Levels in the aclk domain
);

   logic [WIDTH-1:0] stage1;

   // ========================================================================
   // Synchroniser stages, one pair per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // First stage feeds only the second stage
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               stage1[i] <= RESET_VALUE[i];
               sync_out[i] <= RESET_VALUE[i];
            end else if (clock_enable) begin
               stage1[i] <= pin_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule : pin_sync

// File: logic/clock_control_status.sv
// Control and status pin logic of a jitter-attenuating clock multiplier.
// Assumes one 25 MHz clock, AXI4-Lite software access, and pins and reference
// clocks slow enough to sample at that rate.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "clkctl_cfg.svh"

module clock_control_status
   import clkctl_pkg::*;
#(
   parameter int NUM_OUTPUTS = 10,
   parameter int LOS_CYCLES = `LOS_CYCLES,
   parameter int OFFSET_WIDTH = 32
) (
   input wire logic aclk, // System clock, 25 MHz
   input wire logic aresetn, // Bus reset, synchronous, active low
   input wire logic clock_enable, // Freezes all state while low
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   // Device pins
   input wire logic device_reset_n, // Device reset pin, active low
   input wire logic output_disable_in, // High disables all outputs
   input wire logic freq_step_up_in, // Frequency increment pin
   input wire logic freq_step_down_in, // Frequency decrement pin
   input wire logic pll_locked_in, // Lock level from the loop
   input wire logic [3:0] ref_clock_input, // Reference clocks 0 to 3
   input wire logic crystal_pins, // Crystal oscillator signal
   output logic lock_indicator_out, // High while locked
   output logic input0_clock_lost_n, // Input 0 status
   output logic input1_clock_lost_n, // Input 1 status
   output logic input2_clock_lost_n, // Input 2 status
   output logic input3_clock_lost_n, // Input 3 status
   output logic crystal_signal_lost_n, // Crystal status
   output logic [NUM_OUTPUTS-1:0] clock_out_enable, // Per-output enable
   output logic [NUM_OUTPUTS*OFFSET_WIDTH-1:0] freq_offset_out // Per-output offset
);

   localparam int CNT_WIDTH = $clog2(LOS_CYCLES + 1);
   localparam int NUM_MON = 5;
   // ========================================================================
   // Pin synchronisers
   logic [3:0] ctrl_sync;
   logic [NUM_MON-1:0] activity_sync;
   logic locked_sync;

   // Control pins; reset pin rests high so the block is not held in reset
   pin_sync #(.WIDTH(4), .RESET_VALUE(4'h1)) u_ctrl_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clock_enable(clock_enable),
      .pin_in({freq_step_down_in, freq_step_up_in, output_disable_in, device_reset_n}),
      .sync_out(ctrl_sync)
   );

   // Monitored clocks and lock level
   pin_sync #(.WIDTH(NUM_MON + 1), .RESET_VALUE('0)) u_mon_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clock_enable(clock_enable),
      .pin_in({pll_locked_in, crystal_pins, ref_clock_input}),
      .sync_out({locked_sync, activity_sync})
   );

   wire dev_reset_sync = ~ctrl_sync[0];
   wire disable_sync = ctrl_sync[1];
   wire up_sync = ctrl_sync[2];
   wire down_sync = ctrl_sync[3];
   // Block reset: bus reset or device reset pin
   wire block_reset = ~aresetn | dev_reset_sync;
   // ========================================================================
   // Software registers
   logic [`SELECT_WIDTH-1:0] step_select;
   logic [`STEP_WIDTH-1:0] step_size;
   logic [NUM_OUTPUTS-1:0] out_enable_mask;
   logic [OFFSET_WIDTH-1:0] freq_offset [NUM_OUTPUTS];
   // ========================================================================
   // Loss-of-signal monitors: an edge restarts the count, a full count means lost
   logic [NUM_MON-1:0] activity_prev;
   logic [NUM_MON-1:0] lost;
   genvar m;
   generate
      for (m = 0; m < NUM_MON; m++) begin : g_mon
         logic [CNT_WIDTH-1:0] quiet_count;
         wire edge_seen = activity_sync[m] ^ activity_prev[m];
         // Count starts expired so a channel reads lost until a clock is seen
         always_ff @(posedge aclk) begin
            if (block_reset) begin
               activity_prev[m] <= 1'b0;
               quiet_count <= CNT_WIDTH'(LOS_CYCLES);
               lost[m] <= 1'b1;
            end else if (clock_enable) begin
               activity_prev[m] <= activity_sync[m];
               if (edge_seen) begin
                  quiet_count <= '0;
                  lost[m] <= 1'b0;
               end else if (quiet_count != CNT_WIDTH'(LOS_CYCLES)) begin
                  quiet_count <= quiet_count + 1'b1;
               end else begin
                  lost[m] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // ========================================================================
   // Status vector shared by the pins and the status register
   status_type status;
   assign status = '{dev_reset_sync, disable_sync, lost[4], lost[3:0], locked_sync};

   // Status pins, registered; during reset they show lost and unlocked
   always_ff @(posedge aclk) begin
      if (block_reset) begin
         lock_indicator_out <= 1'b0;
         {input3_clock_lost_n, input2_clock_lost_n} <= 2'h0;
         {input1_clock_lost_n, input0_clock_lost_n} <= 2'h0;
         crystal_signal_lost_n <= 1'b0;
      end else if (clock_enable) begin
         lock_indicator_out <= status.locked;
         input0_clock_lost_n <= ~status.input_lost[0];
         input1_clock_lost_n <= ~status.input_lost[1];
         input2_clock_lost_n <= ~status.input_lost[2];
         input3_clock_lost_n <= ~status.input_lost[3];
         crystal_signal_lost_n <= ~status.crystal_lost;
      end
   end

   // Output enables; the synchroniser adds two cycles before a pin reset bites
   always_ff @(posedge aclk) begin
      if (block_reset) begin
         clock_out_enable <= '0;
      end else if (clock_enable) begin
         clock_out_enable <= disable_sync ? '0 : out_enable_mask;
      end
   end

   // ========================================================================
   // Frequency stepping on rising edges only
   logic up_prev;
   logic down_prev;
   wire up_rise = up_sync & ~up_prev;
   wire down_rise = down_sync & ~down_prev;
   // Simultaneous up and down cancel rather than favour one direction
   wire do_up = up_rise & ~down_rise;
   wire do_down = down_rise & ~up_rise;
   wire [OFFSET_WIDTH-1:0] step_ext = OFFSET_WIDTH'(step_size);
   always_ff @(posedge aclk) begin
      if (block_reset) begin
         up_prev <= 1'b0;
         down_prev <= 1'b0;
      end else if (clock_enable) begin
         up_prev <= up_sync;
         down_prev <= down_sync;
      end
   end
   genvar o;
   generate
      for (o = 0; o < NUM_OUTPUTS; o++) begin : g_out
         // A select beyond the last output matches nothing and steps nothing
         wire chosen = (step_select == `SELECT_WIDTH'(o));
         always_ff @(posedge aclk) begin
            if (block_reset) begin
               freq_offset[o] <= '0;
            end else if (clock_enable && chosen && do_up) begin
               freq_offset[o] <= freq_offset[o] + step_ext;
            end else if (clock_enable && chosen && do_down) begin
               freq_offset[o] <= freq_offset[o] - step_ext;
            end
         end
         assign freq_offset_out[o*OFFSET_WIDTH +: OFFSET_WIDTH] = freq_offset[o];
      end
   endgenerate

   // ========================================================================
   // AXI4-Lite write channel: address and data taken in either order
   write_state_type wr_state;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire next_aw_held = aw_held | aw_take;
   wire next_w_held = w_held | w_take;
   wire wr_commit = (wr_state == wr_collect) & next_aw_held & next_w_held;
   wire [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
   wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
   wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
   wire wr_select = wr_commit & (wr_addr[7:2] == `REG_SELECT >> 2);
   wire wr_step = wr_commit & (wr_addr[7:2] == `REG_STEP >> 2);
   wire wr_out_en = wr_commit & (wr_addr[7:2] == `REG_OUT_EN >> 2);
   wire wr_mapped = wr_select | wr_step | wr_out_en;
   // Byte lanes merged into the old value
   function automatic logic [31:0] merge(input logic [31:0] old_value, new_value,
                                         input logic [3:0] strobe);
      logic [31:0] result;
      result = old_value;
      for (int b = 0; b < 4; b++) begin
         if (strobe[b]) begin
            result[b*8 +: 8] = new_value[b*8 +: 8];
         end
      end
      return result;
   endfunction : merge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= wr_collect;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= '0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (clock_enable) begin
         case (wr_state)
            wr_collect: begin
               if (aw_take) aw_addr <= s_axi_awaddr;
               if (w_take) begin
                  w_data <= s_axi_wdata;
                  w_strb <= s_axi_wstrb;
               end
               if (wr_commit) begin
                  wr_state <= wr_answer;
                  aw_held <= 1'b0;
                  w_held <= 1'b0;
                  s_axi_awready <= 1'b0;
                  s_axi_wready <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
               end else begin
                  aw_held <= next_aw_held;
                  w_held <= next_w_held;
                  s_axi_awready <= ~next_aw_held;
                  s_axi_wready <= ~next_w_held;
               end
            end
            wr_answer: begin
               if (s_axi_bready) begin
                  wr_state <= wr_collect;
                  s_axi_bvalid <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
               end
            end
            default: wr_state <= wr_collect;
         endcase
      end
   end

   // Writable registers; the device reset pin restores them too
   always_ff @(posedge aclk) begin
      if (block_reset) begin
         step_select <= `SELECT_RESET;
         step_size <= `STEP_RESET;
         out_enable_mask <= '1;
      end else if (clock_enable) begin
         if (wr_select) step_select <= `SELECT_WIDTH'(merge(32'(step_select), wr_data, wr_strb));
         if (wr_step) step_size <= `STEP_WIDTH'(merge(32'(step_size), wr_data, wr_strb));
         if (wr_out_en) out_enable_mask <= NUM_OUTPUTS'(merge(32'(out_enable_mask), wr_data,
                                                              wr_strb));
      end
   end

   // ========================================================================
   // AXI4-Lite read channel: one cycle to answer
   read_state_type rd_state;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [5:0] rd_index = s_axi_araddr[7:2];
   wire [5:0] offset_index = rd_index - 6'(`REG_OFFSET_BASE >> 2);
   wire rd_is_offset = (rd_index >= 6'(`REG_OFFSET_BASE >> 2)) &
                       (offset_index < 6'(NUM_OUTPUTS));
   wire rd_mapped = rd_is_offset | (rd_index <= 6'(`REG_STATUS >> 2));
   wire [31:0] rd_value =
      (rd_index == 6'(`REG_SELECT >> 2)) ? 32'(step_select) :
      (rd_index == 6'(`REG_STEP >> 2)) ? 32'(step_size) :
      (rd_index == 6'(`REG_OUT_EN >> 2)) ? 32'(out_enable_mask) :
      (rd_index == 6'(`REG_STATUS >> 2)) ? 32'(status) :
      rd_is_offset ? 32'(freq_offset[offset_index[3:0]]) : '0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= rd_idle;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (clock_enable) begin
         case (rd_state)
            rd_idle: begin
               s_axi_arready <= ~ar_take;
               if (ar_take) begin
                  rd_state <= rd_answer;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_value;
                  s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
               end
            end
            rd_answer: begin
               if (s_axi_rready) begin
                  rd_state <= rd_idle;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: rd_state <= rd_idle;
         endcase
      end
   end

endmodule : clock_control_status

// File: bench/clock_control_status_props.sv
// Checker for the clock control and status pins; sees top-level ports only.
// Assumes aclk is the one clock and aresetn its reset.
module clock_control_status_props #(
   parameter int NUM_OUTPUTS = 10,
   parameter int LOS_CYCLES = 50,
   parameter int OFFSET_WIDTH = 32
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Bus reset, active low
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic device_reset_n, // Device reset pin
   input wire logic output_disable_in, // Disable pin
   input wire logic freq_step_up_in, // Increment pin
   input wire logic freq_step_down_in, // Decrement pin
   input wire logic pll_locked_in, // Loop lock level
   input wire logic [3:0] ref_clock_input, // Reference clocks
   input wire logic crystal_pins, // Crystal signal
   input wire logic lock_indicator_out, // Lock pin
   input wire logic input0_clock_lost_n, // Input 0 status
   input wire logic input1_clock_lost_n, // Input 1 status
   input wire logic input2_clock_lost_n, // Input 2 status
   input wire logic input3_clock_lost_n, // Input 3 status
   input wire logic crystal_signal_lost_n, // Crystal status
   input wire logic [NUM_OUTPUTS-1:0] clock_out_enable, // Output enables
   input wire logic [NUM_OUTPUTS*OFFSET_WIDTH-1:0] freq_offset_out // Offsets
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ======================================================================
   // Helper logic
   logic [3:0] up_age;
   logic [4:0] prev_src;
   logic [7:0] quiet [5];
   wire logic [4:0] src = {crystal_pins, ref_clock_input};
   wire logic [4:0] seen_n = {crystal_signal_lost_n, input3_clock_lost_n,
      input2_clock_lost_n, input1_clock_lost_n, input0_clock_lost_n};
   wire logic settled = (up_age == 4'hf);
   // Age since the reset pin was low; hides the synchroniser lag after release
   always_ff @(posedge aclk) begin
      if (!aresetn || !device_reset_n) up_age <= 4'h0;
      else if (!settled) up_age <= up_age + 4'h1;
   end
   // Cycles since each monitored input last changed, saturating
   always_ff @(posedge aclk) begin
      prev_src <= src;
      for (int i = 0; i < 5; i++) begin
         if (!aresetn || src[i] != prev_src[i]) quiet[i] <= 8'h00;
         else if (quiet[i] != 8'hff) quiet[i] <= quiet[i] + 8'h01;
      end
   end
   // ======================================================================
   // Assertions
   sequence dev_reset_held;
      !device_reset_n [*3];
   endsequence
   sequence step_rise;
      ($past(freq_step_up_in, 3) && !$past(freq_step_up_in, 4))
         || ($past(freq_step_down_in, 3) && !$past(freq_step_down_in, 4));
   endsequence
   a_reset_quiets_pins:
      assert property (dev_reset_held |=> clock_out_enable == '0 && !lock_indicator_out
         && seen_n == 5'h00) else $error("outputs active during device reset");
   a_reset_clears_offsets:
      assert property (dev_reset_held |=> freq_offset_out == '0)
         else $error("offsets kept through device reset");
   a_disable_outputs_off:
      assert property (output_disable_in [*3] |=> clock_out_enable == '0)
         else $error("outputs enabled while disable pin high");
   a_enable_needs_pins:
      assert property (clock_out_enable != '0 |-> !$past(output_disable_in, 3)
         && $past(device_reset_n, 3)) else $error("output enabled too early");
   a_lock_tracks_loop:
      assert property ((settled && $stable(pll_locked_in)) [*6]
         |-> lock_indicator_out == pll_locked_in) else $error("lock pin wrong");
   a_step_needs_edge:
      assert property (settled && freq_offset_out != $past(freq_offset_out) |-> step_rise)
         else $error("offset moved without a pin edge");
   a_write_answer_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write response dropped");
   for (genvar g = 0; g < 5; g++) begin : g_mon
      a_lost_when_quiet:
         assert property (quiet[g] >= 8'(LOS_CYCLES + 8) |-> !seen_n[g])
            else $error("silent input not flagged");
      a_seen_when_active:
         assert property ((settled && quiet[g] <= 8'h02) [*8] |-> seen_n[g])
            else $error("active input flagged lost");
   end
endmodule : clock_control_status_props

bind clock_control_status clock_control_status_props #(.NUM_OUTPUTS(NUM_OUTPUTS),
   .LOS_CYCLES(LOS_CYCLES), .OFFSET_WIDTH(OFFSET_WIDTH)) props_inst (.*);

// File: bench/ref_clock_source.sv
// Board-side model of the four reference clocks and the crystal.
// Assumes aclk paces it; each running source toggles every HALF cycles.
module ref_clock_source #(
   parameter int HALF = 2
) (
   input wire logic aclk, // System clock
   input wire logic [4:0] run, // Per source: high keeps it toggling
   output logic [3:0] ref_clock_input, // Reference clocks 0 to 3
   output logic crystal_pins // Crystal signal
);
   timeunit 1ns;
   timeprecision 1ns;
   int count = 0;
   logic [4:0] level = 5'h00;
   assign ref_clock_input = level[3:0];
   assign crystal_pins = level[4];
   // A stopped source freezes at its last level, as a dead oscillator does
   always @(posedge aclk) begin
      count <= (count == HALF - 1) ? 0 : count + 1;
      if (count == 0) level <= level ^ run;
   end
endmodule : ref_clock_source

// File: bench/tb_clock_control_status.sv
// Self-checking bench for the clock control and status pin block.
// Assumes package, header and checker are compiled first.
`include "clkctl_cfg.svh"
module tb_clock_control_status;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOS = 4;
   localparam int NOUT = 10;
   // ======================================================================
   // Signals
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic device_reset_n = 1'b1, output_disable_in = 1'b0, pll_locked_in = 1'b0;
   logic freq_step_up_in = 1'b0, freq_step_down_in = 1'b0, crystal_pins;
   logic [3:0] ref_clock_input;
   logic [4:0] run = 5'h1f;
   logic lock_indicator_out, input0_clock_lost_n, input1_clock_lost_n;
   logic input2_clock_lost_n, input3_clock_lost_n, crystal_signal_lost_n;
   logic [NOUT-1:0] clock_out_enable, msk;
   logic [NOUT*32-1:0] freq_offset_out;
   logic [31:0] exp_off [NOUT] = '{default: 32'h0};
   logic [3:0] sel;
   logic [15:0] stp;
   logic up;
   int errors = 0, checked = 0, seed;
   wire logic [4:0] lost_n = {crystal_signal_lost_n, input3_clock_lost_n,
      input2_clock_lost_n, input1_clock_lost_n, input0_clock_lost_n};
   clock_control_status #(.LOS_CYCLES(LOS)) clock_control_status_inst (.*,
      .clock_enable(1'b1), .s_axi_wstrb(4'hf));
   ref_clock_source ref_clock_source_inst (.aclk, .run, .ref_clock_input, .crystal_pins);
   always #20 aclk = ~aclk;
   // ======================================================================
   // Tasks
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // Bounded wait for an answer; a hang ends the run
   task automatic wait_edge(input int n);
      if (n >= 50) begin
         errors++;
         report_and_stop();
      end
      @(posedge aclk);
   endtask : wait_edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n <= 50; n++) begin
         wait_edge(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            check("write resp", 32'(er), 32'(s_axi_bresp));
            return;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n <= 50; n++) begin
         wait_edge(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            check("read data", e, s_axi_rdata);
            check("read resp", 32'(er), 32'(s_axi_rresp));
            return;
         end
      end
   endtask : rd
   task automatic pulse(input logic up_pin, input int hold);
      @(posedge aclk);
      if (up_pin) freq_step_up_in <= 1'b1;
      else freq_step_down_in <= 1'b1;
      repeat (hold) @(posedge aclk);
      freq_step_up_in <= 1'b0;
      freq_step_down_in <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse
   task automatic check_offsets();
      for (int i = 0; i < NOUT; i++) check("offset", exp_off[i], freq_offset_out[32*i +: 32]);
   endtask : check_offsets
   // ======================================================================
   // Main sequence
   initial begin
      seed = $urandom(22);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_SELECT, 32'h0, `RESP_OKAY);
      rd(`REG_STEP, 32'h1, `RESP_OKAY);
      rd(`REG_OUT_EN, 32'h3ff, `RESP_OKAY);
      rd(8'h40, 32'h0, `RESP_SLVERR);
      wr(`REG_STATUS, 32'hff, `RESP_SLVERR);
      check("enables", 32'h3ff, 32'(clock_out_enable));
      $display("test defaults done");
      // Random steps; selects 10 and 11 are out of range, some pins held long
      for (int k = 0; k < 24; k++) begin
         sel = 4'($urandom_range(0, 11));
         stp = (k == 1) ? 16'hffff : 16'($urandom);
         up = 1'($urandom);
         wr(`REG_SELECT, 32'(sel), `RESP_OKAY);
         wr(`REG_STEP, 32'(stp), `RESP_OKAY);
         pulse(up, (k % 4 == 0) ? 9 : 2);
         if (sel < NOUT) exp_off[sel] = up ? exp_off[sel] + stp : exp_off[sel] - stp;
         check_offsets();
      end
      $display("test steps done");
      msk = 10'($urandom);
      wr(`REG_OUT_EN, 32'(msk), `RESP_OKAY);
      for (int v = 0; v < 3; v++) begin
         output_disable_in <= (v == 1);
         repeat (5) @(posedge aclk);
         check("enables", (v == 1) ? 32'h0 : 32'(msk), 32'(clock_out_enable));
      end
      $display("test disable done");
      for (int v = 0; v < 3; v++) begin
         pll_locked_in <= v[0];
         repeat (8) @(posedge aclk);
         check("lock", 32'(v[0]), 32'(lock_indicator_out));
      end
      $display("test lock done");
      for (int i = 0; i < 5; i++) begin
         run[i] <= 1'b0;
         repeat (LOS + 12) @(posedge aclk);
         check("lost", 32'(5'h1f ^ (5'h01 << i)), 32'(lost_n));
         run[i] <= 1'b1;
         repeat (8) @(posedge aclk);
         check("lost", 32'h1f, 32'(lost_n));
      end
      $display("test monitors done");
      // Reset pin mid-run, then one default-sized step on output 0
      device_reset_n <= 1'b0;
      repeat (5) @(posedge aclk);
      check("enables", 32'h0, 32'(clock_out_enable));
      check("lock", 32'h0, 32'(lock_indicator_out));
      exp_off = '{default: 32'h0};
      check_offsets();
      device_reset_n <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(`REG_SELECT, 32'h0, `RESP_OKAY);
      rd(`REG_OUT_EN, 32'h3ff, `RESP_OKAY);
      pulse(1'b1, 2);
      exp_off[0] = 32'h1;
      check_offsets();
      $display("test device reset done");
      report_and_stop();
   end
endmodule : tb_clock_control_status
